// File: core/ecm_pin_mux.sv
// pin multiplexer for card and flash devices on the external bus
// What this block does
// - I/O-mode card read drives read strobe onto card I/O-read; memory output-enable idle.
// - memory or attribute card read drives read strobe onto output-enable; I/O-read idle.
// - card writes in attribute, common and I/O-write regions drive write strobe onto card write-enable.
// - attribute, common, I/O-write regions: output-enable, write-enable follow; I/O-read held 1.
// - I/O-read region: output-enable and write-enable held 1; I/O-read follows read strobe.
// - card-type bit chooses card buffer select or ordinary chip select on cs4/cs5 pins.
// - card access puts card strobes on shared read, write0, write1 pins.
// - card buffer select 0 has exactly the timing of chip select 4.
// - card direction reads 1 in the first clock of a transfer, then is latched and held to its end.
// - flash-type bit on cs2/cs3 enables flash support for that space.
// - active flash chip select puts strobes on flash output and write enables.
// - flash enables drop at once when address leaves the cs2/cs3 space.
// - flash path carries 16-bit devices, upper byte on data lines 15 to 8.
// - 16-bit static: address 0 and write1 are byte selects; two 8-bit: write strobes.
// - address bits 23 to 21 pick card region attr, I/O write, common, I/O read.
// - device-type bits: card 4/5, flash 2/3, sdram 1; zero means static.
// - card enables follow chip select, carrying byte selects or fixed 0/1 odd-byte.
`timescale 1ns/1ps
module ecm_pin_mux #(
  parameter int unsigned ADDR_WIDTH = ecm_pkg::ADDR_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // device-type selection from the bus select register
  input wire logic [5:0] bus_select_register,
  input wire logic bus_select_load,
  // static memory controller side
  input wire ecm_pkg::ecm_ctl_t ctl,
  input wire logic [ADDR_WIDTH-1:0] transfer_addr,
  input wire logic transfer_write,
  input wire logic transfer_active,
  // dynamic ram controller chip select, active low
  input wire logic sdram_cs_n,
  // pins
  output ecm_pkg::ecm_pin_t pins,
  output logic card_buffer_select0,
  output logic card_buffer_select1,
  // current selection, for status
  output logic [5:0] device_select
);
  initial begin
    if (ADDR_WIDTH < ecm_pkg::REGION_MSB + 1) $error("address too narrow for card region");
  end

  logic [5:0] sel;
  logic card_direction;
  logic prev_active;

  // selection bits are held here; zero at reset keeps every pin a plain static pin
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel <= ecm_pkg::SEL_RESET;
    end else if (bus_select_load) begin
      sel <= bus_select_register;
    end
  end

  // a plain register finds the transfer start; a sampled-value call would not map to gates
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_active <= 1'b0;
    end else begin
      prev_active <= transfer_active;
    end
  end

  wire transfer_start = transfer_active && !prev_active;

  // direction is latched once per transfer so it cannot toggle mid-access
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      card_direction <= 1'b1;
    end else if (!transfer_active) begin
      card_direction <= 1'b1;
    end else if (transfer_start) begin
      card_direction <= !transfer_write;
    end
  end

  assign device_select = sel;

  wire card4_on = sel[ecm_pkg::SEL_CARD4_BIT];
  wire card5_on = sel[ecm_pkg::SEL_CARD5_BIT];
  wire flash2_on = sel[ecm_pkg::SEL_FLASH2_BIT];
  wire flash3_on = sel[ecm_pkg::SEL_FLASH3_BIT];
  wire sdram_on = sel[ecm_pkg::SEL_SDRAM_BIT];

  wire cs4_act = !ctl.chip_select_n[4];
  wire cs5_act = !ctl.chip_select_n[5];
  wire card_access = (card4_on && cs4_act) || (card5_on && cs5_act);
  wire flash_access = (flash2_on && !ctl.chip_select_n[2]) ||
                      (flash3_on && !ctl.chip_select_n[3]);
  wire [2:0] region = transfer_addr[ecm_pkg::REGION_MSB:ecm_pkg::REGION_LSB];

  logic card_oe;
  logic card_we;
  logic card_iord;

  ecm_card_decode u_card (
    .region(region),
    .read_strobe_n(ctl.read_strobe_n),
    .write_strobe0_n(ctl.write_strobe0_n),
    .card_mem_output_enable(card_oe),
    .card_write_strobe(card_we),
    .card_io_read_strobe(card_iord)
  );

  // buffer selects are the chip selects themselves, so timing is identical
  wire cs4_card_sel = card4_on;
  wire cs5_card_sel = card5_on;
  assign card_buffer_select0 = cs4_card_sel ? ctl.chip_select_n[4] : 1'b1;
  assign card_buffer_select1 = cs5_card_sel ? ctl.chip_select_n[5] : 1'b1;

  // chip select pins: card pins carry the buffer select, cs1 may come from the sdram side
  wire [5:0] cs_pin_n = {
    cs5_card_sel ? card_buffer_select1 : ctl.chip_select_n[5],
    cs4_card_sel ? card_buffer_select0 : ctl.chip_select_n[4],
    ctl.chip_select_n[3:2],
    sdram_on ? sdram_cs_n : ctl.chip_select_n[1],
    ctl.chip_select_n[0]
  };

  // card enables mirror the active card chip select, gated by byte selects
  wire card_cs_n = !card_access;
  wire ce_lo = card_cs_n | (ctl.card_odd_byte ? 1'b0 : ctl.byte_select0_n);
  wire ce_hi = card_cs_n | (ctl.card_odd_byte ? 1'b1 : ctl.byte_select1_n);

  // write1 stays the upper byte strobe for static devices; byte lanes pass untouched
  assign pins.chip_select_n = cs_pin_n;
  assign pins.read_strobe_n = card_access ? card_oe : ctl.read_strobe_n;
  assign pins.write_strobe0_n = card_access ? card_we : ctl.write_strobe0_n;
  assign pins.write_strobe1_n = card_access ? card_iord : ctl.write_strobe1_n;
  // flash strobes active low, idle high; width is set by the shared 16-bit data path
  assign pins.flash_output_enable = flash_access ? ctl.read_strobe_n : 1'b1;
  assign pins.flash_write_enable = flash_access ? ctl.write_strobe0_n : 1'b1;
  assign pins.card_direction = card_direction;
  assign pins.card_enable_lo = ce_lo;
  assign pins.card_enable_hi = ce_hi;
endmodule : ecm_pin_mux

// File: include/ecm_pkg.sv
// package for the external bus card and flash pin multiplexer
package ecm_pkg;
  // device-type select bit positions
  localparam int unsigned SEL_SDRAM_BIT = 1;
  localparam int unsigned SEL_FLASH2_BIT = 2;
  localparam int unsigned SEL_FLASH3_BIT = 3;
  localparam int unsigned SEL_CARD4_BIT = 4;
  localparam int unsigned SEL_CARD5_BIT = 5;
  localparam logic [5:0] SEL_RESET = 6'h00;
  // card region field in the transfer address
  localparam int unsigned REGION_MSB = 23;
  localparam int unsigned REGION_LSB = 21;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned NUM_CS = 6;

  typedef enum logic [2:0] {
    ECM_REG_ATTR = 3'b000,
    ECM_REG_IOWR = 3'b001,
    ECM_REG_COMMON = 3'b010,
    ECM_REG_IORD = 3'b100
  } ecm_region_t;

  // strobes from the static memory controller, active low except card_odd_byte
  typedef struct packed {
    logic [5:0] chip_select_n;
    logic read_strobe_n;
    logic write_strobe0_n;
    logic write_strobe1_n;
    logic byte_select0_n;
    logic byte_select1_n;
    logic card_odd_byte;
  } ecm_ctl_t;

  // strobes as they leave on the pins
  typedef struct packed {
    logic [5:0] chip_select_n;
    logic read_strobe_n;
    logic write_strobe0_n;
    logic write_strobe1_n;
    logic flash_output_enable;
    logic flash_write_enable;
    logic card_direction;
    logic card_enable_lo;
    logic card_enable_hi;
  } ecm_pin_t;
endpackage : ecm_pkg

// File: core/ecm_card_decode.sv
// card region decode and card strobe generation
`timescale 1ns/1ps
module ecm_card_decode (
  // controller side
  input wire logic [2:0] region,
  input wire logic read_strobe_n,
  input wire logic write_strobe0_n,
  // card strobes, active low
  output logic card_mem_output_enable,
  output logic card_write_strobe,
  output logic card_io_read_strobe
);
  wire is_io_read = (region == ecm_pkg::ECM_REG_IORD);
  wire is_mem_or_iow = (region == ecm_pkg::ECM_REG_ATTR) || (region == ecm_pkg::ECM_REG_IOWR) ||
                       (region == ecm_pkg::ECM_REG_COMMON);

  // undefined region codes keep every card strobe idle
  assign card_mem_output_enable = is_mem_or_iow ? read_strobe_n : 1'b1;
  assign card_write_strobe = is_mem_or_iow ? write_strobe0_n : 1'b1;
  assign card_io_read_strobe = is_io_read ? read_strobe_n : 1'b1;
endmodule : ecm_card_decode

// File: dv/ecm_pin_mux_asserts.sv
// port assertions for the card and flash pin multiplexer
`timescale 1ns/1ps
module ecm_pin_mux_asserts #(
  parameter int unsigned ADDR_WIDTH = ecm_pkg::ADDR_W
) (
  // clock, reset and selection
  input wire logic clk, input wire logic sys_rst,
  input wire logic [5:0] bus_select_register, input wire logic bus_select_load,
  // controller side
  input wire ecm_pkg::ecm_ctl_t ctl, input wire logic [ADDR_WIDTH-1:0] transfer_addr,
  input wire logic transfer_write, input wire logic transfer_active, input wire logic sdram_cs_n,
  // pins
  input wire ecm_pkg::ecm_pin_t pins, input wire logic card_buffer_select0,
  input wire logic card_buffer_select1, input wire logic [5:0] device_select
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire card4 = device_select[4] && !ctl.chip_select_n[4] && transfer_active;
  wire [2:0] rg = transfer_addr[23:21];
  a_buf0_timing: assert property (device_select[4] |-> card_buffer_select0 == ctl.chip_select_n[4])
    else $error("buffer select 0 differs from cs4");
  a_io_read: assert property (card4 && rg == 3'h4 |-> pins.write_strobe1_n == ctl.read_strobe_n
    && pins.read_strobe_n && pins.write_strobe0_n) else $error("io read routing wrong");
  a_mem_access: assert property (card4 && rg < 3'h3 |-> pins.write_strobe1_n &&
    pins.read_strobe_n == ctl.read_strobe_n && pins.write_strobe0_n == ctl.write_strobe0_n)
    else $error("card memory routing wrong");
  a_flash_strobe: assert property (device_select[2] && !ctl.chip_select_n[2] |->
    pins.flash_write_enable == ctl.write_strobe0_n) else $error("flash write enable wrong");
  a_flash_idle: assert property (&ctl.chip_select_n[3:2] |-> pins.flash_output_enable &&
    pins.flash_write_enable) else $error("flash enable outside its space");
  a_dir_latch: assert property ($rose(transfer_active) |=>
    pins.card_direction == !$past(transfer_write)) else $error("direction not latched");
  a_dir_hold: assert property (transfer_active [*2] |=> $stable(pins.card_direction))
    else $error("direction moved mid transfer");
  a_sel_load: assert property (bus_select_load |=> device_select == $past(bus_select_register))
    else $error("selection not loaded");
  a_static_pins: assert property (device_select == 6'h00 |->
    pins.chip_select_n == ctl.chip_select_n) else $error("static chip selects altered");
endmodule : ecm_pin_mux_asserts
bind ecm_pin_mux ecm_pin_mux_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) u_ecm_pin_mux_asserts (
  .clk(clk), .sys_rst(sys_rst), .bus_select_register(bus_select_register),
  .bus_select_load(bus_select_load), .ctl(ctl), .transfer_addr(transfer_addr),
  .transfer_write(transfer_write), .transfer_active(transfer_active), .sdram_cs_n(sdram_cs_n),
  .pins(pins), .card_buffer_select0(card_buffer_select0),
  .card_buffer_select1(card_buffer_select1), .device_select(device_select));

// File: dv/ecm_flash_model.sv
// far-side flash model that counts the write strobes it is given
`timescale 1ns/1ps
module ecm_flash_model (
  // clock, reset and pins
  input wire logic clk,
  input wire logic sys_rst,
  input wire ecm_pkg::ecm_pin_t pins,
  input wire logic [23:0] transfer_addr,
  // strobes seen
  output logic [7:0] write_count
);
  logic prev_we;
  // chip enable sits on a general i/o line held low, so no standby between strobes
  logic ce_n;
  assign ce_n = 1'b0;
  // board wiring: latch enables on the default address bits
  wire flash_ale = transfer_addr[22];
  wire flash_cle = transfer_addr[21];
  // card side: write and io-write split from the one card write strobe
  wire card_we_n = pins.write_strobe0_n | (transfer_addr[23:21] == 3'h1);
  wire card_iowr_n = pins.write_strobe0_n | (transfer_addr[23:21] != 3'h1);
  // the card never stretches here, so the stall line toward the controller idles high
  wire card_stall_n = 1'b1;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_we <= 1'b1;
      write_count <= 8'h00;
    end else begin
      prev_we <= pins.flash_write_enable;
      if (prev_we && !pins.flash_write_enable && !ce_n) write_count <= write_count + 8'h01;
    end
  end
endmodule : ecm_flash_model

// File: dv/tb_ecm_pin_mux.sv
// bench for the card and flash pin multiplexer
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
module tb_ecm_pin_mux;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [5:0] bus_select_register = 6'h00;
  logic bus_select_load = 1'b0;
  ecm_pkg::ecm_ctl_t ctl = '1;
  logic [23:0] transfer_addr = 24'h000000;
  logic transfer_write = 1'b0;
  logic transfer_active = 1'b0;
  ecm_pkg::ecm_pin_t pins;
  logic card_buffer_select0, card_buffer_select1;
  logic [5:0] device_select;
  logic [7:0] write_count;
  logic [2:0] regs [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
  int err_count = 0;
  int compares = 0;
  always #5 clk = ~clk;
  ecm_pin_mux u_ecm_pin_mux (.clk(clk), .sys_rst(sys_rst), .bus_select_register(bus_select_register),
    .bus_select_load(bus_select_load), .ctl(ctl), .transfer_addr(transfer_addr),
    .transfer_write(transfer_write), .transfer_active(transfer_active), .sdram_cs_n(1'b1),
    .pins(pins), .card_buffer_select0(card_buffer_select0),
    .card_buffer_select1(card_buffer_select1), .device_select(device_select));
  ecm_flash_model u_ecm_flash_model (.clk(clk), .sys_rst(sys_rst), .pins(pins),
    .transfer_addr(transfer_addr), .write_count(write_count));
  // one transfer phase; all-ones chip selects mean idle, which re-arms the direction latch
  task step(input logic [5:0] cs, input logic rd, input logic wr, input logic [2:0] rg);
    @(posedge clk);
    #1;
    ctl.chip_select_n = cs;
    ctl.read_strobe_n = rd;
    ctl.write_strobe0_n = wr;
    transfer_addr = {rg, 21'h000000};
    transfer_write = !wr;
    transfer_active = !(&cs);
    @(posedge clk);
    #2;
  endtask : step
  task tally_and_finish;
    $display("compares %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    #20000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 sys_rst = 1'b0;
    `CHK(device_select, 6'h00)
    step(6'h2f, 1'b0, 1'b1, 3'h4);
    `CHK(pins.read_strobe_n, 1'b0)
    `CHK(card_buffer_select0, 1'b1)
    $display("static pass-through done");
    bus_select_register = 6'h34;
    bus_select_load = 1'b1;
    step(6'h3f, 1'b1, 1'b1, 3'h0);
    bus_select_load = 1'b0;
    `CHK(device_select, 6'h34)
    // cs4/cs5 are used for nothing but the card once given to it
    for (int i = 0; i < 4; i++) begin
      step(6'h2f, 1'b0, 1'b1, regs[i]);
      `CHK(pins.write_strobe1_n, regs[i] != 3'h4)
      `CHK(pins.read_strobe_n, regs[i] == 3'h4)
      `CHK(card_buffer_select0, 1'b0)
      `CHK(pins.card_direction, 1'b1)
      step(6'h3f, 1'b1, 1'b1, 3'h0);
      step(6'h2f, 1'b1, 1'b0, regs[i]);
      `CHK(pins.write_strobe0_n, regs[i] == 3'h4)
      `CHK(pins.card_direction, 1'b0)
      step(6'h3f, 1'b1, 1'b1, 3'h0);
    end
    `CHK(pins.card_direction, 1'b1)
    ctl.byte_select0_n = 1'b0;
    step(6'h1f, 1'b0, 1'b1, 3'h2);
    `CHK(card_buffer_select1, 1'b0)
    `CHK(pins.card_enable_lo, 1'b0)
    `CHK(pins.card_enable_hi, 1'b1)
    ctl.byte_select0_n = 1'b1;
    step(6'h3f, 1'b1, 1'b1, 3'h0);
    `CHK(pins.card_enable_lo, 1'b1)
    step(6'h3b, 1'b0, 1'b1, 3'h1);
    `CHK(pins.flash_output_enable, 1'b0)
    step(6'h3f, 1'b0, 1'b1, 3'h1);
    `CHK(pins.flash_output_enable, 1'b1)
    $display("card regions done");
    step(6'h3b, 1'b1, 1'b0, 3'h1);
    `CHK(pins.flash_write_enable, 1'b0)
    step(6'h3f, 1'b1, 1'b0, 3'h1);
    `CHK(pins.flash_write_enable, 1'b1)
    `CHK(write_count, 8'h01)
    $display("flash strobes done");
    tally_and_finish();
  end
endmodule : tb_ecm_pin_mux
